// ===== src/ckpll_pkg.sv
package ckpll_pkg;

    // ----------------------------------------------------------------
    // register map (word index, byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam logic [9:0]  IDX_OSC_TRIM = 10'h03C;
    localparam logic [9:0]  IDX_PLL_CTRL = 10'h03D;
    localparam logic [9:0]  IDX_OUT_DIV  = 10'h03E;
    localparam logic [9:0]  IDX_STATUS   = 10'h050;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_OSC_TRIM = 8'h80;
    localparam logic [7:0]  RST_PLL_CTRL = 8'h04;
    localparam logic [7:0]  RST_OUT_DIV  = 8'h08;

    // ----------------------------------------------------------------
    // field positions and limits
    // ----------------------------------------------------------------
    localparam int          POS_SEL      = 4;
    localparam int          POS_EN       = 3;
    localparam int          POS_PD       = 2;
    localparam int          POS_FB       = 0;
    localparam logic [7:0]  OUT_DIV_MIN  = 8'h08;
    localparam logic [4:0]  FB_DIV_23    = 5'h17;
    localparam logic [4:0]  FB_DIV_27    = 5'h1B;
    localparam logic [4:0]  FB_DIV_28    = 5'h1C;
    localparam int          PLL_PRE_HALF = 2;
    localparam int          SYNC_STAGES  = 2;

    // clock pin source select codes
    typedef enum logic [3:0] {
        SRC_GPIO  = 4'h0,
        SRC_PLL   = 4'h1,
        SRC_LOW   = 4'h2,
        SRC_HIGH  = 4'h3,
        SRC_XT1   = 4'h4,
        SRC_XT2   = 4'h5,
        SRC_XT4   = 4'h6,
        SRC_XT8   = 4'h7,
        SRC_TMR0  = 4'h8,
        SRC_TMR1  = 4'h9,
        SRC_TMR2  = 4'hA,
        SRC_TMR3  = 4'hB
    } ckpll_src_e;

    // pll and clock pin control register layout
    typedef struct packed {
        logic [3:0] clockPinSourceSelect;
        logic       clockPinOutputEnable;
        logic       pllPowerDown;
        logic [1:0] pllFeedbackDivider;
    } ckpll_ctrl_s;

    // pin drive pair
    typedef struct packed {
        logic level;
        logic enable;
    } ckpll_pin_s;

endpackage : ckpll_pkg

// ===== src/ckpll_clock_ctrl.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module ckpll_clock_ctrl (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ckpll_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           crystalClkIn,
    input  wire logic                           pllClkIn,
    input  wire logic [3:0]                     timerOverflow,
    input  wire logic                           gpioOut,
    input  wire logic                           gpioOutEnable,
    input  wire logic                           clockOutputPinIn,
    output logic                                clockOutputPinOut,
    output logic                                clockOutputPinOe,
    output logic [7:0]                          oscTrimValue,
    output logic [4:0]                          pllFeedbackRatio,
    output logic [7:0]                          pllOutputDivider,
    output logic                                pllPowerDown
);

    // ----------------------------------------------------------------
    // registers and internal signals
    // ----------------------------------------------------------------
    logic [7:0]             oscTrim_ff;
    ckpll_pkg::ckpll_ctrl_s ctrl_ff;
    logic [7:0]             outDiv_ff;
    logic                   ready_ff;
    logic [31:0]            rdata_ff;
    logic                   slvErr_ff;
    logic [1:0]             xtalSync_ff;
    logic                   xtalLast_ff;
    logic [1:0]             pllSync_ff;
    logic [1:0]             pinInSync_ff;
    logic [2:0]             xtalCnt_ff;
    logic                   timerToggle_ff;
    logic                   pllRun_ff;
    logic                   pllDown_ff;
    logic [4:0]             fbRatio_ff;
    ckpll_pkg::ckpll_pin_s  pin_ff;
    ckpll_pkg::ckpll_pin_s  nxt_pin;
    logic [9:0]             wordIdx;
    logic                   accessPhase;
    logic                   wrStrobe;
    logic                   hitTrim;
    logic                   hitCtrl;
    logic                   hitDiv;
    logic                   hitStat;
    logic                   hitAny;
    logic [31:0]            nxt_rdata;
    logic                   xtalRise;
    logic                   divReserved;
    ckpll_pkg::ckpll_src_e  srcSel;
    logic [1:0]             tmrIdx;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // answer lands one cycle into the access phase so that pready,
    // prdata and pslverr can all come straight from flip-flops
    assign wordIdx     = paddr[11:2];
    assign accessPhase = psel & penable;
    assign wrStrobe    = accessPhase & ready_ff & pwrite;
    assign hitTrim     = (wordIdx == ckpll_pkg::IDX_OSC_TRIM);
    assign hitCtrl     = (wordIdx == ckpll_pkg::IDX_PLL_CTRL);
    assign hitDiv      = (wordIdx == ckpll_pkg::IDX_OUT_DIV);
    assign hitStat     = (wordIdx == ckpll_pkg::IDX_STATUS);
    assign hitAny      = hitTrim | hitCtrl | hitDiv | hitStat;

    // pready pulses for one cycle per access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= accessPhase & ~ready_ff;
        end
    end

    // read mux; narrow registers sit in the low byte
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hitTrim) begin
            nxt_rdata[7:0] = oscTrim_ff;
        end else if (hitCtrl) begin
            nxt_rdata[7:0] = ctrl_ff;
        end else if (hitDiv) begin
            nxt_rdata[7:0] = outDiv_ff;
        // status gives software a view of what the pin logic sees
        end else if (hitStat) begin
            nxt_rdata[0] = pllRun_ff;
            nxt_rdata[1] = pinInSync_ff[1];
            nxt_rdata[2] = divReserved;
            nxt_rdata[3] = pin_ff.level;
            nxt_rdata[8:4] = fbRatio_ff;
        end
    end

    // read data and error flag, captured as the answer is raised
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff  <= 32'h0000_0000;
            slvErr_ff <= 1'b0;
        end else if (accessPhase & ~ready_ff) begin
            rdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
            slvErr_ff <= ~hitAny | (pwrite & hitStat);
        end else begin
            slvErr_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // trim code is passed straight to the oscillator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscTrim_ff <= ckpll_pkg::RST_OSC_TRIM;
        end else if (wrStrobe & hitTrim) begin
            oscTrim_ff <= pwdata[7:0];
        end
    end

    // pll and clock pin control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= ckpll_pkg::RST_PLL_CTRL;
        end else if (wrStrobe & hitCtrl) begin
            ctrl_ff <= pwdata[7:0];
        end
    end

    // output divider; reserved codes are stored but not obeyed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outDiv_ff <= ckpll_pkg::RST_OUT_DIV;
        end else if (wrStrobe & hitDiv) begin
            outDiv_ff <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // pll control towards the analog macro
    // ----------------------------------------------------------------
    // codes below the legal minimum would overdrive the divider chain
    assign divReserved = (outDiv_ff < ckpll_pkg::OUT_DIV_MIN);

    // feedback ratio decode; the macro multiplies the crystal by it
    // and halves the product before the output divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fbRatio_ff <= ckpll_pkg::FB_DIV_23;
        end else begin
            case (ctrl_ff.pllFeedbackDivider)
                2'b01:   fbRatio_ff <= ckpll_pkg::FB_DIV_27;
                2'b10:   fbRatio_ff <= ckpll_pkg::FB_DIV_28;
                default: fbRatio_ff <= ckpll_pkg::FB_DIV_23;
            endcase
        end
    end

    // a reserved divider would give an out-of-range clock, so the
    // pll is treated as stopped until a legal value is written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pllRun_ff <= 1'b0;
        end else begin
            pllRun_ff <= ~ctrl_ff.pllPowerDown & ~divReserved;
        end
    end

    // the stop flag has a flop of its own so the port needs no inverter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pllDown_ff <= 1'b1;
        end else begin
            pllDown_ff <= ctrl_ff.pllPowerDown | divReserved;
        end
    end

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // limitation: a clock faster than half of clk aliases here; the
    // pll path to the pin is only a sampled image of the macro output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xtalSync_ff  <= 2'b00;
            pllSync_ff   <= 2'b00;
            pinInSync_ff <= 2'b00;
            xtalLast_ff  <= 1'b0;
        end else begin
            xtalSync_ff  <= {xtalSync_ff[0], crystalClkIn};
            pllSync_ff   <= {pllSync_ff[0], pllClkIn};
            pinInSync_ff <= {pinInSync_ff[0], clockOutputPinIn};
            xtalLast_ff  <= xtalSync_ff[1];
        end
    end

    assign xtalRise = xtalSync_ff[1] & ~xtalLast_ff;

    // ----------------------------------------------------------------
    // crystal dividers
    // ----------------------------------------------------------------
    // one ripple-free counter gives all three binary divisions
    // limitation: the counter runs on from reset, so the first divided
    // period after a select change may be short
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xtalCnt_ff <= 3'h0;
        end else if (xtalRise) begin
            xtalCnt_ff <= xtalCnt_ff + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // timer overflow toggle
    // ----------------------------------------------------------------
    // the low two select bits name the timer in toggle mode
    assign srcSel = ckpll_pkg::ckpll_src_e'(ctrl_ff.clockPinSourceSelect);
    assign tmrIdx = ctrl_ff.clockPinSourceSelect[1:0];

    // only the selected timer may flip the level
    // hazard: the level is kept across select changes, so software
    // reads status bit 3 to learn the phase it starts from
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerToggle_ff <= 1'b0;
        end else if (srcSel[3:2] == 2'b10 && timerOverflow[tmrIdx]) begin
            timerToggle_ff <= ~timerToggle_ff;
        end
    end

    // ----------------------------------------------------------------
    // clock pin source selection
    // ----------------------------------------------------------------
    always_comb begin
        nxt_pin.level  = 1'b0;
        nxt_pin.enable = ctrl_ff.clockPinOutputEnable;
        case (srcSel)
            ckpll_pkg::SRC_GPIO: begin
                nxt_pin.level  = gpioOut;
                nxt_pin.enable = gpioOutEnable;
            end
            ckpll_pkg::SRC_PLL:  nxt_pin.level = pllSync_ff[1] & pllRun_ff;
            ckpll_pkg::SRC_LOW:  nxt_pin.level = 1'b0;
            ckpll_pkg::SRC_HIGH: nxt_pin.level = 1'b1;
            ckpll_pkg::SRC_XT1:  nxt_pin.level = xtalSync_ff[1];
            ckpll_pkg::SRC_XT2:  nxt_pin.level = xtalCnt_ff[0];
            ckpll_pkg::SRC_XT4:  nxt_pin.level = xtalCnt_ff[1];
            ckpll_pkg::SRC_XT8:  nxt_pin.level = xtalCnt_ff[2];
            ckpll_pkg::SRC_TMR0,
            ckpll_pkg::SRC_TMR1,
            ckpll_pkg::SRC_TMR2,
            ckpll_pkg::SRC_TMR3: nxt_pin.level = timerToggle_ff;
            // reserved codes leave the pin undriven
            default:             nxt_pin.enable = 1'b0;
        endcase
        // outside gpio mode, a disabled clock output drives nothing and shows low
        if (srcSel != ckpll_pkg::SRC_GPIO && !nxt_pin.enable) begin
            nxt_pin.level = 1'b0;
        end
    end

    // pin drive is registered to keep glitches off the pad
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_ff <= '0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // every port is a flop image; nothing combinational leaves here
    assign prdata            = rdata_ff;
    assign pready            = ready_ff;
    assign pslverr           = slvErr_ff;
    assign clockOutputPinOut = pin_ff.level;
    assign clockOutputPinOe  = pin_ff.enable;
    assign oscTrimValue      = oscTrim_ff;
    assign pllFeedbackRatio  = fbRatio_ff;
    assign pllOutputDivider  = outDiv_ff;
    assign pllPowerDown      = pllDown_ff;

endmodule : ckpll_clock_ctrl

// ===== tb/ckpll_pin_load.sv
`timescale 1ns/1ps

// ---------------------------------------
// board load on the clock output pin
// ---------------------------------------
module ckpll_pin_load (
    input  wire logic pinOut,
    input  wire logic pinOe,
    input  wire logic extEn,
    input  wire logic extLevel,
    output wire logic pinLevel
);
    // device drive wins; the pull-up keeps a released line defined
    assign pinLevel = pinOe ? pinOut : (extEn ? extLevel : 1'h1);
endmodule : ckpll_pin_load

// ===== tb/ckpll_clock_ctrl_monitor.sv
`timescale 1ns/1ps

// ---------------------------------------
// port checks of the clock pin block
// ---------------------------------------
module ckpll_clock_ctrl_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        clockOutputPinOut,
    input wire logic        clockOutputPinOe,
    input wire logic [7:0]  oscTrimValue,
    input wire logic [4:0]  pllFeedbackRatio,
    input wire logic [7:0]  pllOutputDivider,
    input wire logic        pllPowerDown
);
    // completed writes, split by word index
    wire logic [9:0] idx   = paddr[11:2];
    wire logic       wrEnd = psel && penable && pready && pwrite;
    wire logic       ctlWr = wrEnd && idx == ckpll_pkg::IDX_PLL_CTRL;
    wire logic       trWr  = wrEnd && idx == ckpll_pkg::IDX_OSC_TRIM;
    wire logic       dvWr  = wrEnd && idx == ckpll_pkg::IDX_OUT_DIV;
    wire logic [3:0] sel   = pwdata[7:4];

    // division for each feedback code
    function automatic logic [4:0] fbDiv(input logic [1:0] c);
        return c == 2'h1 ? 5'h1B : (c == 2'h2 ? 5'h1C : 5'h17);
    endfunction : fbDiv

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // pin checks wait three edges: control flop, then pin flop
    chk_trim_store: assert property (
        trWr |=> oscTrimValue == $past(pwdata[7:0])) else $error("trim lost");
    chk_div_store: assert property (
        dvWr |=> pllOutputDivider == $past(pwdata[7:0])) else $error("div lost");
    chk_fb_ratio: assert property (
        ctlWr |-> ##2 pllFeedbackRatio == fbDiv($past(pwdata[1:0], 2)))
        else $error("feedback ratio wrong");
    chk_div_reserved: assert property (
        $stable(pllOutputDivider) && pllOutputDivider < 8'h08 |-> pllPowerDown)
        else $error("reserved divider runs pll");
    chk_pd_bit: assert property (
        ctlWr && pwdata[2] |-> ##2 pllPowerDown) else $error("pll not stopped");
    chk_hold_low: assert property (
        ctlWr && sel == 4'h2 && pwdata[3] |-> ##3
        (clockOutputPinOe && !clockOutputPinOut)[*2]) else $error("pin not low");
    chk_hold_high: assert property (
        ctlWr && sel == 4'h3 && pwdata[3] |-> ##3
        (clockOutputPinOe && clockOutputPinOut)) else $error("pin not high");
    chk_gate_off: assert property (
        ctlWr && sel != 4'h0 && !pwdata[3] |-> ##3 (!clockOutputPinOe)[*2])
        else $error("pin driven while disabled");
endmodule : ckpll_clock_ctrl_monitor

bind ckpll_clock_ctrl ckpll_clock_ctrl_monitor uMon (.*);

// ===== tb/clock_output_pll_control_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nFail++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module clock_output_pll_control_test;
    localparam logic [9:0] TRM = ckpll_pkg::IDX_OSC_TRIM;
    localparam logic [9:0] CTL = ckpll_pkg::IDX_PLL_CTRL;
    localparam logic [9:0] DIV = ckpll_pkg::IDX_OUT_DIV;
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, xtal = 1'h0, pll = 1'h0, gpOut = 1'h0;
    logic        gpOe = 1'h0, extEn = 1'h0, extLv = 1'h0, err, lv;
    logic        pready, pslverr, pinOut, pinOe, pd;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, q, v, seed = 32'h195BAB06;
    logic [3:0]  tmr = 4'h0;
    logic [7:0]  trim, outDiv, dv;
    logic [4:0]  ratio;
    wire logic   pin;
    int          nFail = 0, nTests = 0, cnt, e;

    // bench clock and the two free-running outside sources
    always #2.5 clk = ~clk;
    always #18.437 xtal = ~xtal;
    always #12.826 pll = ~pll;

    ckpll_clock_ctrl DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystalClkIn(xtal),
        .pllClkIn(pll), .timerOverflow(tmr), .gpioOut(gpOut),
        .gpioOutEnable(gpOe), .clockOutputPinIn(pin),
        .clockOutputPinOut(pinOut), .clockOutputPinOe(pinOe),
        .oscTrimValue(trim), .pllFeedbackRatio(ratio),
        .pllOutputDivider(outDiv), .pllPowerDown(pd));
    ckpll_pin_load uLoad (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn),
        .extLevel(extLv), .pinLevel(pin));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // division expected for each feedback code
    function automatic logic [4:0] fbExp(input int c);
        return c == 1 ? 5'h1B : (c == 2 ? 5'h1C : 5'h17);
    endfunction : fbExp

    task endOfTest();
        if (nFail == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : endOfTest

    // one transfer, called just after a rising edge; the request stands
    // until the rising edge that sees pready high, then one idle edge
    task automatic apb(input logic w, input logic [9:0] ix,
                       input logic [7:0] d);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {ix, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
        if (k >= 20) begin
            nFail++;
            endOfTest();
        end
    endtask : apb

    task automatic ctl(input logic [3:0] s, input logic en, input logic p,
                       input logic [1:0] fb);
        apb(1'h1, CTL, {s, en, p, fb});
        repeat (4) @(posedge clk);
    endtask : ctl

    // rising edges of the pin image over n cycles
    task automatic edges(input int n);
        logic prev;
        prev = pin;
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            if (pin === 1'h1 && prev === 1'h0)
                cnt++;
            prev = pin;
        end
    endtask : edges

    task automatic pulse(input logic [3:0] b);
        @(posedge clk);
        tmr <= b;
        @(posedge clk);
        tmr <= 4'h0;
        repeat (4) @(posedge clk);
    endtask : pulse

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        apb(1'h0, TRM, 8'h0);
        `CHK(q, 32'h80)
        apb(1'h0, CTL, 8'h0);
        `CHK(q, 32'h04)
        apb(1'h0, DIV, 8'h0);
        `CHK({q[7:0], pd, ratio}, 14'h0237)
        // random trim codes and legal dividers
        repeat (8) begin
            v = rnd();
            dv = 8'h08 + 8'(v[15:8] % 8'hF7);
            apb(1'h1, TRM, v[7:0]);
            apb(1'h1, DIV, dv);
            apb(1'h0, TRM, 8'h0);
            `CHK({q, trim, outDiv}, {24'h0, v[7:0], v[7:0], dv})
        end
        // every feedback code, pin held low; then held high
        for (int c = 0; c < 4; c++) begin
            ctl(4'h2, 1'h1, 1'h0, 2'(c));
            `CHK({ratio, pinOe, pin}, {fbExp(c), 2'h2})
        end
        ctl(4'h3, 1'h1, 1'h0, 2'h1);
        `CHK({pinOe, pin}, 2'h3)
        apb(1'h1, DIV, 8'h07);
        repeat (4) @(posedge clk);
        `CHK(pd, 1'h1)
        apb(1'h1, DIV, 8'hFE);
        // pll on the pin: still while powered down, running otherwise
        ctl(4'h1, 1'h1, 1'h1, 2'h0);
        edges(200);
        `CHK(cnt, 0)
        ctl(4'h1, 1'h1, 1'h0, 2'h0);
        edges(200);
        `CHK(cnt > 20, 1'h1)
        for (int k = 0; k < 4; k++) begin
            ctl(4'(4 + k), 1'h1, 1'h0, 2'h0);
            edges(1000);
            e = (13560 >> k) / 100;
            `CHK(cnt >= e - 2 && cnt <= e + 2, 1'h1)
        end
        // a foreign overflow must not toggle the pin
        for (int n = 0; n < 4; n++) begin
            ctl(4'(8 + n), 1'h1, 1'h0, 2'h0);
            lv = pin;
            pulse(4'h1 << ((n + 1) % 4));
            `CHK(pin, lv)
            pulse(4'h1 << n);
            `CHK(pin, ~lv)
        end
        ctl(4'hC, 1'h1, 1'h0, 2'h0);
        `CHK(pinOe, 1'h0)
        ctl(4'h5, 1'h0, 1'h0, 2'h0);
        `CHK(pinOe, 1'h0)
        v = rnd();
        @(posedge clk);
        gpOut <= v[0];
        gpOe <= 1'h1;
        ctl(4'h0, 1'h0, 1'h0, 2'h0);
        `CHK({pinOe, pin}, {1'h1, v[0]})
        @(posedge clk);
        gpOe <= 1'h0;
        extEn <= 1'h1;
        extLv <= ~v[0];
        apb(1'h0, ckpll_pkg::IDX_STATUS, 8'h0);
        apb(1'h0, ckpll_pkg::IDX_STATUS, 8'h0);
        `CHK(q[1], ~v[0])
        apb(1'h0, 10'h03F, 8'h0);
        `CHK({err, q}, {1'h1, 32'h0})
        apb(1'h1, ckpll_pkg::IDX_STATUS, 8'hFF);
        `CHK(err, 1'h1)
        endOfTest();
    end
endmodule : clock_output_pll_control_test
